//--- hdl/omd_pkg.sv
// Constants for the output message distributor.
package omd_pkg;
   localparam int CLK_HZ = 10_000_000;
   localparam int PUNCH_CPS = 60;
   // Least spacing rounds up to whole cycles
   localparam int PACE_CYCLES = (CLK_HZ + PUNCH_CPS - 1) / PUNCH_CPS;
   localparam int TIMEOUT_MS = 1000;
   // Longest wait rounds down
   localparam int TIMEOUT_CYCLES = (CLK_HZ / 1000) * TIMEOUT_MS;
   localparam int CNT_W = 24;
   localparam int BUF_CHARS = 120;
   localparam int HOST_W = 7;
   localparam int LINE_W = 5;
   localparam int FIFO_DEPTH = 8;
   localparam int NUM_STATIONS = 16;
   localparam int SEL_W = 4;
   localparam logic [6:0] EOM_CODE = 7'h7f;
   localparam logic HOST_PAR_ODD = 1'b1;
   // Word passed from translator to distributor
   localparam int W_PAR_BIT = 5;
   localparam int W_EOM_BIT = 6;
   localparam int W_FAULT_BIT = 7;
   localparam int WORD_W = 8;
   localparam logic [7:0] WORD_RST = 8'h00;
   localparam logic [7:0] FAULT_WORD = 8'hc0;
endpackage

//--- hdl/omd_fifo.sv
// Small valid/ready FIFO between translator and distributor.
`timescale 1ns/1ps
`default_nettype none
module omd_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic mclk, // Clock
   input wire logic rstn, // Async reset, active low
   input wire logic in_valid, // Word offered
   output logic in_ready, // Space available
   input wire logic [WIDTH-1:0] in_data, // Word in
   output logic out_valid, // Word available
   input wire logic out_ready, // Word taken
   output logic [WIDTH-1:0] out_data // Word out
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [WIDTH-1:0] mem_next [DEPTH];
   logic [PW-1:0] wr_reg, wr_next, rd_reg, rd_next;
   logic [CW-1:0] cnt_reg, cnt_next;
   logic push, pop;

   assign in_ready = (cnt_reg != FULL);
   assign out_valid = (cnt_reg != '0);
   assign out_data = mem_reg[rd_reg];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   genvar i;
   generate
      for (i = 0; i < DEPTH; i++) begin : g_ent
         always_comb begin
            mem_next[i] = (push && wr_reg == PW'(i)) ? in_data : mem_reg[i];
         end
         always_ff @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
               mem_reg[i] <= '0;
            end else begin
               mem_reg[i] <= mem_next[i];
            end
         end
      end
   endgenerate

   always_comb begin
      wr_next = wr_reg;
      rd_next = rd_reg;
      cnt_next = cnt_reg;
      if (push) begin
         wr_next = (wr_reg == LAST) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
         rd_next = (rd_reg == LAST) ? '0 : rd_reg + 1'b1;
      end
      if (push && !pop) begin
         cnt_next = cnt_reg + 1'b1;
      end else if (pop && !push) begin
         cnt_next = cnt_reg - 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end else begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
         cnt_reg <= cnt_next;
      end
   end
endmodule
`default_nettype wire

//--- hdl/omd_distributor.sv
// Output message path: character buffer, translator and station distributor.
`timescale 1ns/1ps
`default_nettype none
module omd_distributor #(
   parameter int BUF_CHARS = omd_pkg::BUF_CHARS,
   parameter int NUM_STATIONS = omd_pkg::NUM_STATIONS,
   parameter int FIFO_DEPTH = omd_pkg::FIFO_DEPTH,
   parameter int PACE_CYC = omd_pkg::PACE_CYCLES,
   parameter int TIMEOUT_CYC = omd_pkg::TIMEOUT_CYCLES
) (
   input wire logic mclk, // 10 MHz clock
   input wire logic rstn, // Async reset, active low
   input wire logic host_valid, // Host character offered
   output logic host_ready, // Buffer accepting characters
   input wire logic [6:0] host_char, // Seven-level host code
   input wire logic host_par, // Host parity bit
   input wire logic host_sel_mode, // Present by selection, not sequence
   input wire logic host_sel_go, // Request the selected character
   input wire logic [6:0] host_sel_idx, // Buffer index to present
   input wire logic host_sel_done, // End selective presentation
   output logic host_sel_ack, // Selected character passed on
   input wire logic err_clr, // Clear both error flags
   output logic err_parity, // Sticky parity failure
   output logic err_timeout, // Sticky character timeout
   output logic chr_req, // Punch control requests a character
   output logic [NUM_STATIONS-1:0] pch_connect, // One-hot station connection
   output logic [5:0] pch_data, // Parity and five-level code
   output logic pch_strobe, // Record the character
   output logic [3:0] station_id, // Station last selected
   output logic busy // Message in progress
);
   localparam int IW = $clog2(BUF_CHARS);
   localparam int CW = omd_pkg::CNT_W;
   localparam int WW = omd_pkg::WORD_W;
   localparam logic [IW-1:0] BUF_LAST = IW'(BUF_CHARS - 1);
   localparam logic [CW-1:0] PACE_LAST = CW'(PACE_CYC - 1);
   localparam logic [CW-1:0] TOUT_LAST = CW'(TIMEOUT_CYC - 1);

   typedef enum logic [0:0] {T_LOAD, T_SEND} omd_tstate_e;
   typedef enum logic [1:0] {D_SCAN, D_REQ, D_PUNCH, D_FLUSH} omd_dstate_e;

   // Host character with parity, recoded for the line
   function automatic logic [7:0] omd_xlate(input logic [7:0] hc);
      logic [4:0] code;
      logic eom;
      code = hc[4:0];
      eom = (hc[6:0] == omd_pkg::EOM_CODE);
      omd_xlate = {1'b0, eom, ~^code, code};
   endfunction

   // Character buffer
   logic [7:0] buf_reg [BUF_CHARS];
   logic [7:0] buf_next [BUF_CHARS];
   logic buf_we;

   // Translator state
   omd_tstate_e t_state_reg, t_state_next;
   logic [IW-1:0] wr_idx_reg, wr_idx_next;
   logic [IW-1:0] rd_idx_reg, rd_idx_next;
   logic [IW-1:0] last_idx_reg, last_idx_next;
   logic err_par_reg, err_par_next;
   logic [7:0] cur_char;
   logic [IW-1:0] cur_idx;
   logic cur_par_ok;
   logic push_valid;
   logic [WW-1:0] push_word;
   logic f_in_ready;

   // Distributor state
   omd_dstate_e d_state_reg, d_state_next;
   logic [NUM_STATIONS-1:0] conn_reg, conn_next;
   logic [5:0] data_reg, data_next;
   logic strobe_reg, strobe_next;
   logic [3:0] stn_reg, stn_next;
   logic last_reg, last_next;
   logic [CW-1:0] cnt_reg, cnt_next;
   logic err_tout_reg, err_tout_next;
   logic f_valid, f_ready;
   logic [WW-1:0] f_word;
   logic w_eom, w_fault;
   logic [3:0] w_sel;

   genvar i;
   generate
      for (i = 0; i < BUF_CHARS; i++) begin : g_buf
         always_comb begin
            buf_next[i] = buf_reg[i];
            if (buf_we && wr_idx_reg == IW'(i)) begin
               buf_next[i] = {host_par, host_char};
            end
         end
         always_ff @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
               buf_reg[i] <= '0;
            end else begin
               buf_reg[i] <= buf_next[i];
            end
         end
      end
   endgenerate

   // Selection indices past the loaded count are refused while sending
   assign cur_idx = host_sel_mode ? host_sel_idx[IW-1:0] : rd_idx_reg;
   assign cur_char = buf_reg[cur_idx];
   assign cur_par_ok = ((^cur_char) == omd_pkg::HOST_PAR_ODD);
   assign host_ready = (t_state_reg == T_LOAD);
   assign buf_we = host_ready && host_valid;

   always_comb begin
      t_state_next = t_state_reg;
      wr_idx_next = wr_idx_reg;
      rd_idx_next = rd_idx_reg;
      last_idx_next = last_idx_reg;
      err_par_next = err_par_reg && !err_clr;
      push_valid = 1'b0;
      push_word = omd_pkg::WORD_RST;
      host_sel_ack = 1'b0;
      unique case (t_state_reg)
         T_LOAD: begin
            if (buf_we) begin
               if (host_char == omd_pkg::EOM_CODE || wr_idx_reg == BUF_LAST) begin
                  t_state_next = T_SEND;
                  // Index of the end code, or of the last slot when full
                  last_idx_next = wr_idx_reg;
                  rd_idx_next = '0;
               end else begin
                  wr_idx_next = wr_idx_reg + 1'b1;
               end
            end
         end
         T_SEND: begin
            // Selective mode only presents indices that were loaded
            if (host_sel_mode) begin
               push_valid = host_sel_go && (cur_idx <= last_idx_reg);
            end else begin
               push_valid = 1'b1;
            end
            push_word = cur_par_ok ? omd_xlate(cur_char) : omd_pkg::FAULT_WORD;
            if (push_valid && f_in_ready) begin
               host_sel_ack = host_sel_mode;
               if (!cur_par_ok) begin
                  // Rest of a faulted buffer is dropped, not sent
                  err_par_next = 1'b1;
                  t_state_next = T_LOAD;
                  wr_idx_next = '0;
               end else if (!host_sel_mode) begin
                  if (rd_idx_reg == last_idx_reg) begin
                     t_state_next = T_LOAD;
                     wr_idx_next = '0;
                  end else begin
                     rd_idx_next = rd_idx_reg + 1'b1;
                  end
               end
            end
            if (host_sel_mode && host_sel_done && !(push_valid && f_in_ready)) begin
               t_state_next = T_LOAD;
               wr_idx_next = '0;
            end
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         t_state_reg <= T_LOAD;
         wr_idx_reg <= '0;
         rd_idx_reg <= '0;
         last_idx_reg <= '0;
         err_par_reg <= 1'b0;
      end else begin
         t_state_reg <= t_state_next;
         wr_idx_reg <= wr_idx_next;
         rd_idx_reg <= rd_idx_next;
         last_idx_reg <= last_idx_next;
         err_par_reg <= err_par_next;
      end
   end

   // Buffering decouples translator bursts from the slow punch pace
   omd_fifo #(
      .WIDTH(WW),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .mclk(mclk),
      .rstn(rstn),
      .in_valid(push_valid),
      .in_ready(f_in_ready),
      .in_data(push_word),
      .out_valid(f_valid),
      .out_ready(f_ready),
      .out_data(f_word)
   );

   assign w_eom = f_word[omd_pkg::W_EOM_BIT];
   assign w_fault = f_word[omd_pkg::W_FAULT_BIT];
   assign w_sel = f_word[omd_pkg::SEL_W-1:0];

   always_comb begin
      d_state_next = d_state_reg;
      conn_next = conn_reg;
      data_next = data_reg;
      strobe_next = 1'b0;
      stn_next = stn_reg;
      last_next = last_reg;
      cnt_next = cnt_reg;
      err_tout_next = err_tout_reg && !err_clr;
      f_ready = 1'b0;
      chr_req = 1'b0;
      unique case (d_state_reg)
         D_SCAN: begin
            f_ready = 1'b1;
            if (f_valid && !w_eom && !w_fault) begin
               if (int'(w_sel) < NUM_STATIONS) begin
                  conn_next = '0;
                  conn_next[w_sel] = 1'b1;
                  stn_next = w_sel;
                  cnt_next = '0;
                  d_state_next = D_REQ;
               end else begin
                  // Unknown station: discard the message
                  d_state_next = D_FLUSH;
               end
            end
         end
         D_REQ: begin
            chr_req = 1'b1;
            f_ready = f_valid;
            if (f_valid) begin
               if (w_fault) begin
                  conn_next = '0;
                  d_state_next = D_SCAN;
               end else begin
                  data_next = f_word[5:0];
                  strobe_next = 1'b1;
                  last_next = w_eom;
                  cnt_next = '0;
                  d_state_next = D_PUNCH;
               end
            end else if (cnt_reg == TOUT_LAST) begin
               // Only idle waiting is counted, so punch pacing cannot trip it
               err_tout_next = 1'b1;
               conn_next = '0;
               d_state_next = D_FLUSH;
            end else begin
               cnt_next = cnt_reg + 1'b1;
            end
         end
         D_PUNCH: begin
            // Strobes end up PACE_CYC + 1 cycles apart, just under the punch limit
            if (cnt_reg == PACE_LAST) begin
               cnt_next = '0;
               if (last_reg) begin
                  conn_next = '0;
                  d_state_next = D_SCAN;
               end else begin
                  d_state_next = D_REQ;
               end
            end else begin
               cnt_next = cnt_reg + 1'b1;
            end
         end
         D_FLUSH: begin
            // Limitation: a message abandoned without its end code keeps this
            // state until the next end or fault word, which may be a later message
            f_ready = 1'b1;
            if (f_valid && (w_eom || w_fault)) begin
               d_state_next = D_SCAN;
            end
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         d_state_reg <= D_SCAN;
         conn_reg <= '0;
         data_reg <= '0;
         strobe_reg <= 1'b0;
         stn_reg <= '0;
         last_reg <= 1'b0;
         cnt_reg <= '0;
         err_tout_reg <= 1'b0;
      end else begin
         d_state_reg <= d_state_next;
         conn_reg <= conn_next;
         data_reg <= data_next;
         strobe_reg <= strobe_next;
         stn_reg <= stn_next;
         last_reg <= last_next;
         cnt_reg <= cnt_next;
         err_tout_reg <= err_tout_next;
      end
   end

   assign pch_connect = conn_reg;
   assign pch_data = data_reg;
   assign pch_strobe = strobe_reg;
   assign station_id = stn_reg;
   assign err_parity = err_par_reg;
   assign err_timeout = err_tout_reg;
   assign busy = (t_state_reg != T_LOAD) || (d_state_reg != D_SCAN);
endmodule
`default_nettype wire

//--- testbench/omd_distributor_checker.sv
// Port assertions for the output message distributor.
`timescale 1ns/1ps
`default_nettype none
module omd_distributor_checker #(
   parameter int NUM_STATIONS = omd_pkg::NUM_STATIONS,
   parameter int PACE_CYC = omd_pkg::PACE_CYCLES
) (
   input wire logic mclk, // Clock
   input wire logic rstn, // Reset, active low
   input wire logic host_valid, // Host offer
   input wire logic host_ready, // Buffer loading
   input wire logic [6:0] host_char, // Host code
   input wire logic host_sel_ack, // Selected char pushed
   input wire logic err_parity, // Parity flag
   input wire logic err_timeout, // Timeout flag
   input wire logic chr_req, // Character request
   input wire logic [NUM_STATIONS-1:0] pch_connect, // Station connection
   input wire logic [5:0] pch_data, // Punch data
   input wire logic pch_strobe, // Punch strobe
   input wire logic [3:0] station_id, // Selected station
   input wire logic busy // Message in progress
);
   int gap_reg;
   int gap_next;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   // Saturates so the full-size pace cannot overflow
   always_comb begin
      gap_next = (gap_reg > PACE_CYC) ? gap_reg : gap_reg + 1;
      if (pch_strobe)
         gap_next = 1;
   end
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn)
         gap_reg <= PACE_CYC + 1;
      else
         gap_reg <= gap_next;
   end
   property p_strobe_pulse;
      pch_strobe |=> !pch_strobe;
   endproperty
   a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe too long");
   property p_strobe_after_req;
      pch_strobe |-> $past(chr_req);
   endproperty
   a_strobe_after_req: assert property (p_strobe_after_req) else $error("no request");
   property p_pace;
      pch_strobe |-> gap_reg > PACE_CYC;
   endproperty
   a_pace: assert property (p_pace) else $error("strobes too close");
   property p_line_parity;
      pch_strobe |-> ^pch_data;
   endproperty
   a_line_parity: assert property (p_line_parity) else $error("even line parity");
   property p_onehot;
      $onehot0(pch_connect);
   endproperty
   a_onehot: assert property (p_onehot) else $error("several stations");
   property p_strobe_connected;
      pch_strobe |-> pch_connect != '0;
   endproperty
   a_strobe_connected: assert property (p_strobe_connected) else $error("no link");
   property p_station_match;
      pch_connect != '0 |-> pch_connect[station_id];
   endproperty
   a_station_match: assert property (p_station_match) else $error("wrong station");
   property p_no_switch;
      pch_connect != '0 && $past(pch_connect) != '0 |-> $stable(pch_connect);
   endproperty
   a_no_switch: assert property (p_no_switch) else $error("station switched");
   property p_load_stop;
      host_valid && host_ready && host_char == omd_pkg::EOM_CODE |=> !host_ready;
   endproperty
   a_load_stop: assert property (p_load_stop) else $error("loading past end");
   property p_scan_idle;
      !busy |-> pch_connect == '0 && !chr_req;
   endproperty
   a_scan_idle: assert property (p_scan_idle) else $error("idle but connected");
   property p_timeout_drop;
      $rose(err_timeout) |-> ##[0:1] pch_connect == '0;
   endproperty
   a_timeout_drop: assert property (p_timeout_drop) else $error("timeout kept link");
   c_strobe: cover property (pch_strobe);
   c_parity: cover property ($rose(err_parity));
   c_select: cover property (host_sel_ack);
endmodule
bind omd_distributor omd_distributor_checker #(
   .NUM_STATIONS(NUM_STATIONS), .PACE_CYC(PACE_CYC)) u_chk (
   .mclk(mclk), .rstn(rstn), .host_valid(host_valid), .host_ready(host_ready),
   .host_char(host_char), .host_sel_ack(host_sel_ack), .err_parity(err_parity),
   .err_timeout(err_timeout), .chr_req(chr_req), .pch_connect(pch_connect),
   .pch_data(pch_data), .pch_strobe(pch_strobe), .station_id(station_id), .busy(busy)
);
`default_nettype wire

//--- testbench/omd_punch_model.sv
// Tape punch model standing at the selected output substation.
`timescale 1ns/1ps
`default_nettype none
module omd_punch_model #(
   parameter int NUM_STATIONS = 16
) (
   input wire logic mclk, // Clock
   input wire logic rstn, // Reset, active low
   input wire logic [NUM_STATIONS-1:0] pch_connect, // Station connection
   input wire logic [5:0] pch_data, // Parity and line code
   input wire logic pch_strobe, // Record strobe
   output logic [15:0] n_punched, // Characters recorded
   output logic [5:0] last_code, // Last character recorded
   output logic [15:0] n_bad_par, // Characters with even parity
   output logic [15:0] n_msgs // Messages closed by leader
);
   logic linked;
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         n_punched <= '0;
         last_code <= '0;
         n_bad_par <= '0;
         n_msgs <= '0;
         linked <= 1'b0;
      end else begin
         if (pch_strobe) begin
            n_punched <= n_punched + 1'b1;
            last_code <= pch_data;
            if (^pch_data !== 1'b1)
               n_bad_par <= n_bad_par + 1'b1;
         end
         // Leader spaces messages so the reader can find the next start
         if (linked && pch_connect == '0)
            n_msgs <= n_msgs + 1'b1;
         linked <= pch_connect != '0;
      end
   end
endmodule
`default_nettype wire

//--- testbench/output_message_distributor_test.sv
// Self-checking bench for the output message distributor.
`timescale 1ns/1ps
`default_nettype none
module output_message_distributor_test;
   localparam logic [6:0] EOM = omd_pkg::EOM_CODE;
   logic mclk, rstn, host_valid, host_par, host_sel_mode, host_sel_go, host_sel_done, err_clr;
   logic host_ready, host_sel_ack, err_parity, err_timeout, chr_req, pch_strobe, busy;
   logic [6:0] host_char, host_sel_idx;
   logic [15:0] pch_connect, n_punched, n_bad_par, n_msgs;
   logic [5:0] pch_data, last_code;
   logic [3:0] station_id;
   int n_fail;
   int checked;
   // Short pace and timeout keep the run brief
   omd_distributor #(.PACE_CYC(4), .TIMEOUT_CYC(50)) dut (
      .mclk(mclk), .rstn(rstn), .host_valid(host_valid), .host_ready(host_ready),
      .host_char(host_char), .host_par(host_par), .host_sel_mode(host_sel_mode),
      .host_sel_go(host_sel_go), .host_sel_idx(host_sel_idx), .host_sel_done(host_sel_done),
      .host_sel_ack(host_sel_ack), .err_clr(err_clr), .err_parity(err_parity),
      .err_timeout(err_timeout), .chr_req(chr_req), .pch_connect(pch_connect),
      .pch_data(pch_data), .pch_strobe(pch_strobe), .station_id(station_id), .busy(busy));
   omd_punch_model #(.NUM_STATIONS(16)) punch (
      .mclk(mclk), .rstn(rstn), .pch_connect(pch_connect), .pch_data(pch_data),
      .pch_strobe(pch_strobe), .n_punched(n_punched), .last_code(last_code),
      .n_bad_par(n_bad_par), .n_msgs(n_msgs));
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic conclude;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic load(input logic [6:0] q[$], input int bad);
      foreach (q[i]) begin
         host_valid <= 1'b1;
         host_char <= q[i];
         host_par <= ~^q[i] ^ (i == bad);
         #1;
         while (host_ready !== 1'b1) begin
            @(posedge mclk);
            #1;
         end
         @(posedge mclk);
      end
      host_valid <= 1'b0;
   endtask
   task automatic punch_chk(input logic [6:0] c);
      logic [15:0] k;
      k = n_punched + 1'b1;
      for (int i = 0; i < 100 && n_punched !== k; i++) begin
         @(posedge mclk);
         #1;
      end
      chk("punch count", k, n_punched);
      chk("punch data", {~^c[4:0], c[4:0]}, last_code);
   endtask
   task automatic wait_idle;
      for (int i = 0; i < 400 && pch_connect !== '0; i++) begin
         @(posedge mclk);
         #1;
      end
   endtask
   task automatic send_msg(input logic [6:0] sel, input logic [6:0] body[$]);
      logic [15:0] m0;
      logic [6:0] q[$];
      m0 = n_msgs;
      q = body;
      q.push_front(sel);
      q.push_back(EOM);
      @(posedge mclk);
      load(q, -1);
      foreach (body[i]) punch_chk(body[i]);
      chk("station id", 16'(sel[3:0]), 16'(station_id));
      chk("connection", 16'h0001 << sel[3:0], pch_connect);
      punch_chk(EOM);
      wait_idle();
      chk("released", 16'h0000, pch_connect);
      chk("scanning", 16'h0000, 16'(busy));
      // The punch sees the release one edge after it happens
      @(posedge mclk);
      #1;
      chk("leader", m0 + 1'b1, n_msgs);
   endtask
   task automatic parity_fault;
      logic [15:0] p0;
      logic [6:0] q[$];
      p0 = n_punched;
      q = '{7'h43, 7'h11, EOM};
      @(posedge mclk);
      load(q, 1);
      for (int i = 0; i < 50 && err_parity !== 1'b1; i++) @(posedge mclk);
      #1;
      chk("parity flag", 16'h0001, 16'(err_parity));
      wait_idle();
      chk("nothing punched", p0, n_punched);
      chk("ready again", 16'h0001, 16'(host_ready));
      @(posedge mclk);
      err_clr <= 1'b1;
      @(posedge mclk);
      err_clr <= 1'b0;
      #1;
      chk("parity cleared", 16'h0000, 16'(err_parity));
   endtask
   task automatic pick(input logic [6:0] idx, input logic exp);
      int i;
      @(posedge mclk);
      host_sel_go <= 1'b1;
      host_sel_idx <= idx;
      #1;
      for (i = 0; i < 10 && host_sel_ack !== 1'b1; i++) begin
         @(posedge mclk);
         #1;
      end
      @(posedge mclk);
      host_sel_go <= 1'b0;
      chk("select ack", 16'(exp), 16'(i < 10));
   endtask
   task automatic select_timeout;
      logic [6:0] q[$];
      q = '{7'h47, 7'h15, 7'h16, EOM};
      @(posedge mclk);
      host_sel_mode <= 1'b1;
      load(q, -1);
      pick(7'd9, 1'b0);
      pick(7'd0, 1'b1);
      pick(7'd2, 1'b1);
      punch_chk(7'h16);
      chk("station id", 16'h0007, 16'(station_id));
      for (int i = 0; i < 300 && err_timeout !== 1'b1; i++) @(posedge mclk);
      #1;
      chk("timeout flag", 16'h0001, 16'(err_timeout));
      wait_idle();
      chk("timeout release", 16'h0000, pch_connect);
      // Selection must still be on when the end of selection is taken
      @(posedge mclk);
      host_sel_done <= 1'b1;
      err_clr <= 1'b1;
      @(posedge mclk);
      host_sel_done <= 1'b0;
      host_sel_mode <= 1'b0;
      err_clr <= 1'b0;
      #1;
      chk("selection ended", 16'h0001, 16'(host_ready));
      chk("timeout cleared", 16'h0000, 16'(err_timeout));
   endtask
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   initial begin
      repeat (6000) @(posedge mclk);
      n_fail++;
      conclude();
   end
   initial begin
      n_fail = 0;
      checked = 0;
      rstn = 1'b0;
      {host_valid, host_par, host_sel_mode, host_sel_go, host_sel_done, err_clr} = '0;
      host_char = '0;
      host_sel_idx = '0;
      repeat (4) @(posedge mclk);
      #1;
      chk("reset ready", 16'h0001, 16'(host_ready));
      chk("reset link", 16'h0000, pch_connect);
      chk("reset request", 16'h0000, 16'({busy, chr_req, pch_strobe}));
      @(posedge mclk);
      rstn <= 1'b1;
      send_msg(7'h45, '{7'h31, 7'h2a, 7'h03, 7'h14, 7'h09,
         7'h1b, 7'h22, 7'h0e, 7'h17, 7'h3c});
      send_msg(7'h4c, '{7'h05, 7'h1e});
      parity_fault();
      select_timeout();
      chk("line parity", 16'h0000, n_bad_par);
      conclude();
   end
endmodule
`default_nettype wire
